// file: include/uoec_pkg.sv
// Package for the OUT endpoint configuration block: map, fields, types
package uoec_pkg;

  // Endpoint count and register geometry
  localparam int unsigned NUM_EP     = 7;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned DATA_W     = 8;
  localparam int unsigned OFFS_W     = 12;
  localparam int unsigned SPACE_W    = 16;

  // Per-endpoint register block: 8 slots per endpoint, endpoint n at n*8
  localparam logic [2:0] SLOT_CONFIG = 3'h0;
  localparam logic [2:0] SLOT_XBASE  = 3'h1;
  localparam logic [2:0] SLOT_YBASE  = 3'h5;
  localparam logic [ADDR_W-1:0] EP_STRIDE = 8'h08;

  // Configuration field positions
  localparam int unsigned BIT_ENABLE = 7;
  localparam int unsigned BIT_ISO    = 6;
  localparam int unsigned BIT_TOGGLE = 5;
  localparam int unsigned BIT_DOUBLE_BUFFER_ENABLE   = 4;
  localparam int unsigned BIT_STALL  = 3;
  localparam int unsigned SIZE_HIGH_BITS_LSB   = 0;
  localparam int unsigned SIZE_HIGH_BITS_W     = 3;

  // Value after reset (the documented value is undefined; zero chosen)
  localparam logic [DATA_W-1:0] CONFIG_RESET = 8'h00;
  localparam logic [DATA_W-1:0] BASE_RESET   = 8'h00;

  // Buffer offset and isochronous count geometry
  localparam int unsigned ALIGN_BITS  = 4;
  localparam int unsigned CNT_LOW_W   = 7;
  localparam int unsigned ISO_CNT_W   = 10;

  // Decoded endpoint view toward the buffer manager
  typedef struct packed {
    logic                  access_en;
    logic                  iso;
    logic                  data1;
    logic                  double_buffer_enable;
    logic                  stall;
    logic [SIZE_HIGH_BITS_W-1:0]     size_high;
  } uoec_ep_view_t;

  // Handshake answer for a host access
  typedef enum logic [3:0] {
    UOEC_HS_NONE  = 4'h1,
    UOEC_HS_ACK   = 4'h2,
    UOEC_HS_STALL = 4'h4,
    UOEC_HS_IGN   = 4'h8
  } uoec_hs_t;

endpackage : uoec_pkg

// file: rtl/uoec_ep_regs.sv
// One OUT endpoint: configuration and base registers with toggle update
`timescale 1ns/1ps
module uoec_ep_regs
  import uoec_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // Register writes
  input  wire logic              cfg_we_i,
  input  wire logic              xb_we_i,
  input  wire logic              yb_we_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  // Toggle advance from the serial interface engine
  input  wire logic              pkt_done_i,
  // Register contents
  output logic [DATA_W-1:0]      cfg_o,
  output logic [DATA_W-1:0]      xb_o,
  output logic [DATA_W-1:0]      yb_o
);

  logic [DATA_W-1:0] cfg_q;
  logic [DATA_W-1:0] cfg_d;
  logic [DATA_W-1:0] xb_q;
  logic [DATA_W-1:0] yb_q;
  logic              flip;

  // Toggle flips only for a completed non-iso packet
  assign flip = pkt_done_i & cfg_q[BIT_ENABLE] & ~cfg_q[BIT_ISO];

  // Write loads the byte; hardware toggle flip wins a same-cycle write
  always_comb begin
    cfg_d = cfg_q;
    if (cfg_we_i) begin
      cfg_d = wdata_i;
    end
    if (flip) begin
      cfg_d[BIT_TOGGLE] = ~cfg_q[BIT_TOGGLE];
    end
  end

  // Storage, one config and two base bytes per endpoint
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_q <= CONFIG_RESET;
      xb_q  <= BASE_RESET;
      yb_q  <= BASE_RESET;
    end else begin
      cfg_q <= cfg_d;
      if (xb_we_i) begin
        xb_q <= wdata_i;
      end
      if (yb_we_i) begin
        yb_q <= wdata_i;
      end
    end
  end

  assign cfg_o = cfg_q;
  assign xb_o  = xb_q;
  assign yb_o  = yb_q;

endmodule : uoec_ep_regs

// file: rtl/uoec_buf_sel.sv
// Buffer choice and address forming for the selected endpoint
`timescale 1ns/1ps
module uoec_buf_sel
  import uoec_pkg::*;
(
  // Decoded endpoint view and its base bytes
  input  uoec_ep_view_t          view_i,
  input  wire logic [DATA_W-1:0] xb_i,
  input  wire logic [DATA_W-1:0] yb_i,
  input  wire logic [SPACE_W-1:0] space_base_i,
  input  wire logic [CNT_LOW_W-1:0] cnt_low_i,
  // Results
  output logic                   use_y_o,
  output logic [OFFS_W-1:0]      offset_o,
  output logic [SPACE_W-1:0]     addr_o,
  output logic [ISO_CNT_W-1:0]   count_o
);

  logic [DATA_W-1:0] base_sel;

  // Y only when double buffered and DATA1 expected
  assign use_y_o  = view_i.double_buffer_enable & view_i.data1 & ~view_i.iso;
  assign base_sel = use_y_o ? yb_i : xb_i;
  // Base byte gives offset bits 11..4, low nibble zero
  assign offset_o = {base_sel, {ALIGN_BITS{1'b0}}};
  // Actual address is register space base plus offset
  assign addr_o   = space_base_i + SPACE_W'(offset_o);
  // Iso byte count: three high bits plus seven low bits
  assign count_o  = view_i.iso ? {view_i.size_high, cnt_low_i}
                               : ISO_CNT_W'(cnt_low_i);

endmodule : uoec_buf_sel

// file: rtl/uoec_top.sv
// OUT endpoint configuration and buffer placement for seven endpoints
//
// How it works
// - Seven endpoints, each own configuration byte.
// - Bit 7 enables buffer manager access.
// - Bit 6 picks iso, reinterprets low bits.
// - Bit 5 holds expected DATA0/DATA1 phase.
// - Single buffer mode uses X only.
// - Double buffer: DATA0 X, DATA1 Y.
// - Stall bit answers STALL to accesses of an enabled non-iso endpoint.
// - Iso bits 2..0 give size high.
// - Separate X and Y base registers.
// - Base byte is offset bits 11..4.
// - Low four offset bits forced zero.
// - Offset added to register space base.
// - Reset value undefined; software initialises (registers reset to zero here).
// - Iso byte count ten bits wide.
`timescale 1ns/1ps
module uoec_top
  import uoec_pkg::*;
#(
  parameter int unsigned EPS = NUM_EP
) (
  // Clock and reset
  input  wire logic                 sys_clk_i,
  input  wire logic                 rst_i,
  // Register port
  input  wire logic [ADDR_W-1:0]    reg_addr_i,
  input  wire logic [DATA_W-1:0]    reg_wdata_i,
  input  wire logic                 reg_we_i,
  input  wire logic                 reg_re_i,
  output logic [DATA_W-1:0]         reg_rdata_o,
  // Module register space base
  input  wire logic [SPACE_W-1:0]   space_base_i,
  // Host access from the serial interface engine
  input  wire logic                 host_req_i,
  input  wire logic [2:0]           host_ep_i,
  input  wire logic                 pkt_done_i,
  input  wire logic [CNT_LOW_W-1:0] cnt_low_i,
  // Buffer manager view of the addressed endpoint
  output logic                      bm_access_o,
  output logic                      bm_use_y_o,
  output logic [SPACE_W-1:0]        bm_addr_o,
  output logic [ISO_CNT_W-1:0]      bm_count_o,
  output uoec_hs_t                  hs_o,
  output logic [EPS-1:0]            double_buffer_enable_en_o
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  logic [4:0]          sel_ep;
  logic [2:0]          sel_slot;
  logic                ep_hit;
  logic [2:0]          ep_idx;

  // Endpoint n (1..7) sits at n*8; index 0 and above 7 unmapped
  assign sel_ep   = reg_addr_i[7:3];
  assign sel_slot = reg_addr_i[2:0];
  assign ep_hit   = (sel_ep >= 5'h01) && (sel_ep <= 5'(EPS));
  assign ep_idx   = 3'(sel_ep - 5'h01);

  ////////////////////////////////////////////////////////////////////////
  // Per-endpoint registers

  logic [DATA_W-1:0]   cfg   [EPS];
  logic [DATA_W-1:0]   xb    [EPS];
  logic [DATA_W-1:0]   yb    [EPS];
  logic [2:0]          hep;
  logic                hep_ok;

  // Host endpoint number 1..7 maps to index 0..6
  assign hep    = host_ep_i - 3'h1;
  assign hep_ok = (host_ep_i != 3'h0) && (32'(host_ep_i) <= EPS);

  // One register set per endpoint, written only when addressed
  for (genvar g = 0; g < EPS; g++) begin : g_ep
    logic hit;
    assign hit = reg_we_i & ep_hit & (ep_idx == 3'(g));
    uoec_ep_regs u_regs (
      .sys_clk_i  (sys_clk_i),
      .rst_i      (rst_i),
      .cfg_we_i   (hit & (sel_slot == SLOT_CONFIG)),
      .xb_we_i    (hit & (sel_slot == SLOT_XBASE)),
      .yb_we_i    (hit & (sel_slot == SLOT_YBASE)),
      .wdata_i    (reg_wdata_i),
      .pkt_done_i (pkt_done_i & hep_ok & (hep == 3'(g))),
      .cfg_o      (cfg[g]),
      .xb_o       (xb[g]),
      .yb_o       (yb[g])
    );
    assign double_buffer_enable_en_o[g] = cfg[g][BIT_DOUBLE_BUFFER_ENABLE];
  end

  ////////////////////////////////////////////////////////////////////////
  // Read back

  logic [DATA_W-1:0]   rd_sel;
  logic [DATA_W-1:0]   rdata_q;

  // Unmapped slots and endpoints read zero
  assign rd_sel = !ep_hit                   ? 8'h00 :
                  (sel_slot == SLOT_CONFIG) ? cfg[ep_idx] :
                  (sel_slot == SLOT_XBASE)  ? xb[ep_idx] :
                  (sel_slot == SLOT_YBASE)  ? yb[ep_idx] : 8'h00;

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_q <= 8'h00;
    end else begin
      rdata_q <= reg_re_i ? rd_sel : 8'h00;
    end
  end
  assign reg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////
  // Field decode for the host-addressed endpoint

  logic [DATA_W-1:0]   hcfg;
  uoec_ep_view_t       view;

  assign hcfg            = hep_ok ? cfg[hep] : 8'h00;
  assign view.access_en  = hcfg[BIT_ENABLE];
  assign view.iso        = hcfg[BIT_ISO];
  // Non-iso fields read as zero in iso mode and vice versa
  assign view.data1      = ~hcfg[BIT_ISO] & hcfg[BIT_TOGGLE];
  assign view.double_buffer_enable       = ~hcfg[BIT_ISO] & hcfg[BIT_DOUBLE_BUFFER_ENABLE];
  assign view.stall      = ~hcfg[BIT_ISO] & hcfg[BIT_STALL];
  assign view.size_high  = hcfg[BIT_ISO] ?
                           hcfg[SIZE_HIGH_BITS_LSB +: SIZE_HIGH_BITS_W] : 3'h0;

  ////////////////////////////////////////////////////////////////////////
  // Buffer choice and address

  logic                use_y;
  logic [SPACE_W-1:0]  addr;
  logic [ISO_CNT_W-1:0] count;

  uoec_buf_sel u_sel (
    .view_i       (view),
    .xb_i         (hep_ok ? xb[hep] : 8'h00),
    .yb_i         (hep_ok ? yb[hep] : 8'h00),
    .space_base_i (space_base_i),
    .cnt_low_i    (cnt_low_i),
    .use_y_o      (use_y),
    .offset_o     (),
    .addr_o       (addr),
    .count_o      (count)
  );

  ////////////////////////////////////////////////////////////////////////
  // Handshake and registered outputs

  uoec_hs_t            hs_d;
  uoec_hs_t            hs_q;
  logic                acc_q;
  logic                use_y_q;
  logic [SPACE_W-1:0]  addr_q;
  logic [ISO_CNT_W-1:0] count_q;
  logic                acc_ok;

  // Inactive endpoint never reaches the buffer manager; stall beats access
  assign acc_ok = host_req_i & view.access_en & ~view.stall;
  assign hs_d   = !host_req_i      ? UOEC_HS_NONE  :
                  !view.access_en  ? UOEC_HS_IGN   :
                  view.stall       ? UOEC_HS_STALL :
                                     UOEC_HS_ACK;

  // Answer registered one cycle after the host request
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      hs_q    <= UOEC_HS_NONE;
      acc_q   <= 1'b0;
      use_y_q <= 1'b0;
      addr_q  <= '0;
      count_q <= '0;
    end else begin
      hs_q    <= hs_d;
      acc_q   <= acc_ok;
      use_y_q <= acc_ok & use_y;
      addr_q  <= acc_ok ? addr : '0;
      count_q <= acc_ok ? count : '0;
    end
  end

  assign hs_o        = hs_q;
  assign bm_access_o = acc_q;
  assign bm_use_y_o  = use_y_q;
  assign bm_addr_o   = addr_q;
  assign bm_count_o  = count_q;

endmodule : uoec_top

// file: tb/uoec_props.sv
// Port checker for the OUT endpoint configuration block
`timescale 1ns/1ps
module uoec_props
  import uoec_pkg::*;
#(
  parameter int unsigned EPS = NUM_EP
) (
  // Clock, reset and register port
  input wire logic                 sys_clk_i,
  input wire logic                 rst_i,
  input wire logic [ADDR_W-1:0]    reg_addr_i,
  input wire logic [DATA_W-1:0]    reg_wdata_i,
  input wire logic                 reg_we_i,
  input wire logic                 reg_re_i,
  input wire logic [DATA_W-1:0]    reg_rdata_o,
  // Host side and buffer manager view
  input wire logic [SPACE_W-1:0]   space_base_i,
  input wire logic                 host_req_i,
  input wire logic [2:0]           host_ep_i,
  input wire logic                 pkt_done_i,
  input wire logic [CNT_LOW_W-1:0] cnt_low_i,
  input wire logic                 bm_access_o,
  input wire logic                 bm_use_y_o,
  input wire logic [SPACE_W-1:0]   bm_addr_o,
  input wire logic [ISO_CNT_W-1:0] bm_count_o,
  input wire uoec_hs_t             hs_o,
  input wire logic [EPS-1:0]       double_buffer_enable_en_o
);
  // Mapped register slot decode and base low nibble
  wire logic       map_ok = reg_addr_i[7:3] inside {[1:7]} &&
    reg_addr_i[2:0] inside {SLOT_CONFIG, SLOT_XBASE, SLOT_YBASE};
  wire logic [3:0] sb_low = space_base_i[3:0];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);

  idle_quiet_a: assert property (!host_req_i |=>
    hs_o == UOEC_HS_NONE && !bm_access_o) else $error("answer without req");
  stall_block_a: assert property (host_req_i ##1
    hs_o == UOEC_HS_STALL |-> !bm_access_o) else $error("stall gave access");
  refuse_block_a: assert property (hs_o == UOEC_HS_IGN
    |-> !bm_access_o) else $error("disabled endpoint accessed");
  access_ack_a: assert property (bm_access_o |->
    hs_o == UOEC_HS_ACK) else $error("access without ack");
  align_low_a: assert property (bm_access_o |->
    bm_addr_o[3:0] == $past(sb_low)) else $error("buffer not aligned");
  count_low_a: assert property (bm_access_o |->
    bm_count_o[6:0] == $past(cnt_low_i)) else $error("count low bits");
  read_idle_a: assert property (!reg_re_i |=>
    reg_rdata_o == 8'h00) else $error("read data held");
  unmapped_zero_a: assert property (reg_re_i && !map_ok |=>
    reg_rdata_o == 8'h00) else $error("unmapped read not zero");
  base_back_a: assert property (reg_we_i && map_ok &&
    reg_addr_i[2:0] != SLOT_CONFIG ##1 reg_re_i && $stable(reg_addr_i)
    |=> reg_rdata_o == $past(reg_wdata_i, 2)) else $error("base readback");

  // Main scenarios reached
  cover property (hs_o == UOEC_HS_STALL);
  cover property (hs_o == UOEC_HS_IGN);
  cover property (bm_use_y_o);
  cover property (bm_access_o && bm_count_o[9:7] == 3'h7);
endmodule : uoec_props

bind uoec_top uoec_props #(.EPS(EPS)) uoec_props_i (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
  .reg_rdata_o(reg_rdata_o), .space_base_i(space_base_i),
  .host_req_i(host_req_i), .host_ep_i(host_ep_i), .pkt_done_i(pkt_done_i),
  .cnt_low_i(cnt_low_i), .bm_access_o(bm_access_o), .bm_use_y_o(bm_use_y_o),
  .bm_addr_o(bm_addr_o), .bm_count_o(bm_count_o), .hs_o(hs_o),
  .double_buffer_enable_en_o(double_buffer_enable_en_o));

// file: tb/uoec_host_model.sv
// Host side model: endpoint accesses as the serial engine makes them
`timescale 1ns/1ps
module uoec_host_model (
  // Clock
  input  wire logic  clk_i,
  // Access toward the block
  output logic       req_o,
  output logic [2:0] ep_o,
  output logic       done_o,
  output logic [6:0] cnt_o
);
  // Idle lines at time zero
  initial begin
    req_o = 1'b0;
    ep_o = 3'h0;
    done_o = 1'b0;
    cnt_o = 7'h00;
  end

  // One access pulse; afterwards ep and count lines show inverted values, req and done go low
  task automatic access(input logic [2:0] n, input logic [6:0] k,
                        input logic d);
    @(posedge clk_i);
    req_o <= 1'b1;
    ep_o <= n;
    cnt_o <= k;
    done_o <= d;
    @(posedge clk_i);
    req_o <= 1'b0;
    done_o <= 1'b0;
    ep_o <= ~n;
    cnt_o <= ~k;
  endtask : access
endmodule : uoec_host_model

// file: tb/uoec_top_tb_top.sv
// Self-checking bench for the OUT endpoint configuration block
`timescale 1ns/1ps
module uoec_top_tb_top
  import uoec_pkg::*;
;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  reg_addr_i = 8'h00;
  logic [7:0]  reg_wdata_i = 8'h00;
  logic        reg_we_i = 1'b0;
  logic        reg_re_i = 1'b0;
  logic [15:0] space_base_i = 16'h0000;
  logic        host_req_i, pkt_done_i, bm_access_o, bm_use_y_o;
  logic [2:0]  host_ep_i;
  logic [6:0]  cnt_low_i, double_buffer_enable_en_o, dm, de;
  logic [7:0]  reg_rdata_o, c;
  logic [15:0] bm_addr_o;
  logic [9:0]  bm_count_o;
  uoec_hs_t    hs_o;
  logic [7:0]  cfg [1:7] = '{default: 8'h00};
  logic [7:0]  xb [1:7] = '{default: 8'h00};
  logic [7:0]  yb [1:7] = '{default: 8'h00};
  logic [7:0]  rq [$];
  logic [31:0] hq [$];
  logic [31:0] e;
  logic [6:0]  kk;
  logic        d, rpend = 1'b0, hpend = 1'b0;
  int          fails = 0, cmp_count = 0;

  always #20 sys_clk_i = ~sys_clk_i;

  uoec_top uoec_top_i (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i), .reg_rdata_o(reg_rdata_o),
    .space_base_i(space_base_i), .host_req_i(host_req_i),
    .host_ep_i(host_ep_i), .pkt_done_i(pkt_done_i), .cnt_low_i(cnt_low_i),
    .bm_access_o(bm_access_o), .bm_use_y_o(bm_use_y_o),
    .bm_addr_o(bm_addr_o), .bm_count_o(bm_count_o), .hs_o(hs_o),
    .double_buffer_enable_en_o(double_buffer_enable_en_o));
  uoec_host_model uoec_host_model_i (.clk_i(sys_clk_i), .req_o(host_req_i),
    .ep_o(host_ep_i), .done_o(pkt_done_i), .cnt_o(cnt_low_i));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic test_done;
    $display("mismatches %0d of %0d compares", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : test_done

  // Expected read data from the register model
  function automatic logic [7:0] rexp(input logic [7:0] a);
    if (a[7:6] != 2'h0 || a[5:3] == 3'h0) return 8'h00;
    if (a[2:0] == SLOT_CONFIG) return cfg[a[5:3]];
    if (a[2:0] == SLOT_XBASE) return xb[a[5:3]];
    if (a[2:0] == SLOT_YBASE) return yb[a[5:3]];
    return 8'h00;
  endfunction : rexp

  // Expected answer {hs, access, use_y, addr, count} to one host access
  function automatic logic [31:0] hexp(input int n, input logic [6:0] k);
    logic y;
    y = !cfg[n][6] && cfg[n][4] && cfg[n][5];
    if (!cfg[n][7]) return {UOEC_HS_IGN, 28'h0};
    if (!cfg[n][6] && cfg[n][3]) return {UOEC_HS_STALL, 28'h0};
    return {UOEC_HS_ACK, 1'b1, y, space_base_i + {4'h0, y ? yb[n] : xb[n],
      4'h0}, cfg[n][6] ? cfg[n][2:0] : 3'h0, k};
  endfunction : hexp

  // One register bus cycle; op is {write, read}
  task automatic bus(input logic [1:0] op, input int n, input logic [2:0] s,
                     input logic [7:0] v);
    @(posedge sys_clk_i);
    reg_we_i <= op[1];
    reg_re_i <= op[0];
    // Five endpoint bits so that numbers above 7 reach unmapped space
    reg_addr_i <= {5'(n), s};
    reg_wdata_i <= v;
    if (op[0]) rq.push_back(rexp({5'(n), s}));
  endtask : bus

  // Result watcher: oldest note against what the outputs show
  always @(negedge sys_clk_i) begin
    if (rpend) check(32'(reg_rdata_o), 32'(rq.pop_front()));
    if (hpend) begin
      e = hq.pop_front();
      if (e[27]) check({hs_o, bm_access_o, bm_use_y_o, bm_addr_o,
        bm_count_o}, e);
      else check(32'({hs_o, bm_access_o}), 32'(e[31:27]));
    end
    rpend = reg_re_i;
    hpend = host_req_i;
  end

  initial begin
    repeat (100000) @(posedge sys_clk_i);
    fails++;
    test_done();
  end

  initial begin
    void'($urandom(55514));
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    space_base_i <= 16'($urandom);
    bus(2'b01, 1, SLOT_CONFIG, 8'h00);
    for (int r = 0; r < 8; r++) begin
      for (int n = 1; n < 8; n++) begin
        c = 8'($urandom);
        cfg[n] = c[6] ? c & 8'hC7 : c & 8'hF8;
        xb[n] = 8'($urandom);
        yb[n] = 8'($urandom);
        bus(2'b10, n, SLOT_CONFIG, cfg[n]);
        bus(2'b10, n, SLOT_XBASE, xb[n]);
        bus(2'b01, n, SLOT_XBASE, 8'h00);
        bus(2'b10, n, SLOT_YBASE, yb[n]);
        bus(2'b01, n, SLOT_YBASE, 8'h00);
        bus(2'b10, n, 3'h3, 8'hFF);
        bus(2'b01, n, 3'h3, 8'h00);
        bus(2'b01, 8 + n, SLOT_CONFIG, 8'h00);
      end
      bus(2'b00, 0, 3'h0, 8'h00);
      @(negedge sys_clk_i);
      for (int n = 1; n < 8; n++) begin
        dm[n-1] = !cfg[n][6];
        de[n-1] = cfg[n][4];
      end
      check(32'(double_buffer_enable_en_o & dm), 32'(de & dm));
      for (int k = 0; k < 28; k++) begin
        kk = 7'($urandom);
        d = !(cfg[k%7+1][3] && !cfg[k%7+1][6]) && 1'($urandom);
        hq.push_back(hexp(k % 7 + 1, kk));
        if (d && cfg[k%7+1][7] && !cfg[k%7+1][6]) begin
          cfg[k%7+1][5] = ~cfg[k%7+1][5];
        end
        uoec_host_model_i.access(3'(k % 7 + 1), kk, d);
      end
      for (int n = 1; n < 8; n++) bus(2'b01, n, SLOT_CONFIG, 8'h00);
      bus(2'b00, 0, 3'h0, 8'h00);
    end
    repeat (4) @(posedge sys_clk_i);
    if (rq.size() + hq.size() != 0) fails++;
    test_done();
  end
endmodule : uoec_top_tb_top
